// ==== src/cscb_core.v ====
// Functional notes
// - Compare-skip-equal skips next instruction when both registers are equal.
// - Compares subtract without storing, updating Z, N, V, C, H in one cycle.
// - Register bit skips test one register bit, skip when condition holds.
// - I/O bit skips test one I/O register bit, skip when condition holds.
// - Branch on status bit set jumps PC plus displacement plus one; 1/2 cycles.
// - Branch on status bit clear jumps same way when bit is zero.
// - Carry branches jump when carry is one or zero respectively.
// - Same-or-higher jumps on carry zero; lower jumps on carry one.
// - Signed greater-or-equal jumps when N xor V is zero.
// - Signed less-than jumps when N xor V is one.
// - Half-carry branches jump when half-carry is one or zero.
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`include "cscb_defines.vh"

module cscb_core #(
  parameter PC_W = 16,
  parameter IO_BITS = 256
) (
  pclk,
  presetn,
  ce,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  prog_addr,
  prog_data,
  io_regs_in
);
  input wire pclk;
  input wire presetn;
  input wire ce;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [7:0] paddr;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output wire pready;
  output wire pslverr;
  output wire [PC_W-1:0] prog_addr;
  input wire [15:0] prog_data;
  input wire [IO_BITS-1:0] io_regs_in;

  localparam ST_EXEC = 2'h0;
  localparam ST_SKIPCHK = 2'h1;
  localparam ST_WAIT = 2'h2;

  // Instruction class decode
  function [3:0] op_class;
    input [15:0] w;
    begin
      if ((w & `CSCB_M6) == `CSCB_P_COMPARE_SKIP_EQUAL)
        op_class = `CSCB_OP_COMPARE_SKIP_EQUAL;
      else if ((w & `CSCB_M6) == `CSCB_P_COMPARE_REGS)
        op_class = `CSCB_OP_COMPARE_REGS;
      else if ((w & `CSCB_M6) == `CSCB_P_COMPARE_REGS_WITH_CARRY)
        op_class = `CSCB_OP_COMPARE_REGS_WITH_CARRY;
      else if ((w & `CSCB_M4) == `CSCB_P_COMPARE_IMMEDIATE)
        op_class = `CSCB_OP_COMPARE_IMMEDIATE;
      else if ((w & `CSCB_M_REG_BIT) == `CSCB_P_SKIP_REG_BIT_CLEAR)
        op_class = `CSCB_OP_SKIP_REG_BIT_CLEAR;
      else if ((w & `CSCB_M_REG_BIT) == `CSCB_P_SKIP_REG_BIT_SET)
        op_class = `CSCB_OP_SKIP_REG_BIT_SET;
      else if ((w & `CSCB_M8) == `CSCB_P_SKIP_IO_BIT_CLEAR)
        op_class = `CSCB_OP_SKIP_IO_BIT_CLEAR;
      else if ((w & `CSCB_M8) == `CSCB_P_SKIP_IO_BIT_SET)
        op_class = `CSCB_OP_SKIP_IO_BIT_SET;
      else if ((w & `CSCB_M6) == `CSCB_P_BRANCH_STATUS_BIT_SET)
        op_class = `CSCB_OP_BRANCH_STATUS_BIT_SET;
      else if ((w & `CSCB_M6) == `CSCB_P_BRANCH_STATUS_BIT_CLEAR)
        op_class = `CSCB_OP_BRANCH_STATUS_BIT_CLEAR;
      else
        op_class = `CSCB_OP_OTHER;
    end
  endfunction

  reg [PC_W-1:0] pc_r;
  reg [PC_W-1:0] pc_nxt;
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [7:0] flags_r;
  reg [7:0] flags_nxt;
  reg run_r;
  reg [4:0] regsel_r;
  reg [31:0] retired_r;
  reg [7:0] wreg [0:31];
  integer i;

  wire [3:0] cls;
  wire [4:0] rd_idx;
  wire [4:0] src_idx;
  wire [7:0] rd_val;
  wire [7:0] src_val;
  wire [7:0] imm;
  wire [7:0] cmp_b;
  wire reg_bit;
  wire io_bit;
  wire flag_sel;
  wire [PC_W-1:0] disp;
  wire two_word;
  wire c_o;
  wire z_o;
  wire n_o;
  wire v_o;
  wire s_o;
  wire h_o;
  wire setup;
  wire acc;
  wire wr;
  wire mapped;

  // Operand fields of the fetched word
  assign cls = op_class(prog_data);
  assign rd_idx = (cls == `CSCB_OP_COMPARE_IMMEDIATE) ?
                  {`CSCB_IMM_DEST_HI, prog_data[7:4]} : prog_data[8:4];
  assign src_idx = {prog_data[9], prog_data[3:0]};
  assign rd_val = wreg[rd_idx];
  assign src_val = wreg[src_idx];
  assign imm = {prog_data[11:8], prog_data[3:0]};
  assign cmp_b = (cls == `CSCB_OP_COMPARE_IMMEDIATE) ? imm : src_val;
  assign reg_bit = rd_val[prog_data[2:0]];
  assign io_bit = io_regs_in[prog_data[7:0]];
  // Aliased flag branches all reduce to one selected status bit
  assign flag_sel = flags_r[prog_data[2:0]];
  // Signed word offset, sign-extended to the counter width
  assign disp = {{(PC_W-7){prog_data[9]}}, prog_data[9:3]};
  assign two_word = ((prog_data & `CSCB_M_LDS) == `CSCB_P_LDS) |
                    ((prog_data & `CSCB_M_JMP) == `CSCB_P_JMP);

  cscb_cmp u_cmp (
    .a(rd_val),
    .b(cmp_b),
    .carry_in(flags_r[`CSCB_FLAG_C]),
    .use_carry(cls == `CSCB_OP_COMPARE_REGS_WITH_CARRY),
    .zero_in(flags_r[`CSCB_FLAG_Z]),
    .flag_c(c_o),
    .flag_z(z_o),
    .flag_n(n_o),
    .flag_v(v_o),
    .flag_s(s_o),
    .flag_h(h_o)
  );

  // Execution sequencer: next counter, flags and state
  always @*
  begin
    pc_nxt = pc_r;
    state_nxt = state_r;
    flags_nxt = flags_r;
    case (state_r)
      ST_EXEC:
      begin
        if (run_r)
        begin
          pc_nxt = pc_r + 1'b1;
          case (cls)
            `CSCB_OP_COMPARE_SKIP_EQUAL:
              if (rd_val == src_val)
                state_nxt = ST_SKIPCHK;
            `CSCB_OP_COMPARE_REGS, `CSCB_OP_COMPARE_REGS_WITH_CARRY,
            `CSCB_OP_COMPARE_IMMEDIATE:
            begin
              flags_nxt[`CSCB_FLAG_C] = c_o;
              flags_nxt[`CSCB_FLAG_Z] = z_o;
              flags_nxt[`CSCB_FLAG_N] = n_o;
              flags_nxt[`CSCB_FLAG_V] = v_o;
              flags_nxt[`CSCB_FLAG_S] = s_o;
              flags_nxt[`CSCB_FLAG_H] = h_o;
            end
            `CSCB_OP_SKIP_REG_BIT_CLEAR:
              if (!reg_bit)
                state_nxt = ST_SKIPCHK;
            `CSCB_OP_SKIP_REG_BIT_SET:
              if (reg_bit)
                state_nxt = ST_SKIPCHK;
            `CSCB_OP_SKIP_IO_BIT_CLEAR:
              if (!io_bit)
                state_nxt = ST_SKIPCHK;
            `CSCB_OP_SKIP_IO_BIT_SET:
              if (io_bit)
                state_nxt = ST_SKIPCHK;
            `CSCB_OP_BRANCH_STATUS_BIT_SET:
              if (flag_sel)
              begin
                pc_nxt = pc_r + disp + 1'b1;
                state_nxt = ST_WAIT;
              end
            `CSCB_OP_BRANCH_STATUS_BIT_CLEAR:
              if (!flag_sel)
              begin
                pc_nxt = pc_r + disp + 1'b1;
                state_nxt = ST_WAIT;
              end
            default:
              state_nxt = ST_EXEC;
          endcase
        end
      end
      ST_SKIPCHK:
      begin
        // The skipped word is fetched only to learn its length
        if (two_word)
        begin
          pc_nxt = pc_r + 2'h2;
          state_nxt = ST_WAIT;
        end
        else
        begin
          pc_nxt = pc_r + 1'b1;
          state_nxt = ST_EXEC;
        end
      end
      ST_WAIT:
        state_nxt = ST_EXEC;
      default:
        state_nxt = ST_EXEC;
    endcase
  end

  // APB decode; zero wait states, stalled while the clock enable is low
  assign setup = psel & ~penable;
  assign acc = psel & penable;
  assign wr = acc & pwrite & ce;
  assign pready = ce;
  assign mapped = (paddr == `CSCB_ADDR_CTRL) | (paddr == `CSCB_ADDR_PC) |
                  (paddr == `CSCB_ADDR_FLAGS) | (paddr == `CSCB_ADDR_REGSEL) |
                  (paddr == `CSCB_ADDR_REGDATA) | (paddr == `CSCB_ADDR_RETIRED);
  assign pslverr = acc & ~mapped;
  assign prog_addr = pc_r;

  // Core state; software writes override the sequencer in the same cycle
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pc_r <= `CSCB_PC_RST;
      state_r <= ST_EXEC;
      flags_r <= `CSCB_FLAGS_RST;
      run_r <= 1'b0;
      regsel_r <= 5'h00;
      retired_r <= 32'h00000000;
      for (i = 0; i < 32; i = i + 1)
        wreg[i] <= 8'h00;
    end
    else if (ce)
    begin
      pc_r <= pc_nxt;
      state_r <= state_nxt;
      flags_r <= flags_nxt;
      if (run_r && state_r == ST_EXEC)
        retired_r <= retired_r + 1'b1;
      if (wr && paddr == `CSCB_ADDR_CTRL)
        run_r <= pwdata[`CSCB_CTRL_RUN];
      if (wr && paddr == `CSCB_ADDR_PC)
      begin
        pc_r <= pwdata[PC_W-1:0];
        state_r <= ST_EXEC; // Abandon any skip or branch in flight
      end
      if (wr && paddr == `CSCB_ADDR_FLAGS)
        flags_r <= pwdata[7:0];
      if (wr && paddr == `CSCB_ADDR_REGSEL)
        regsel_r <= pwdata[4:0];
      if (wr && paddr == `CSCB_ADDR_REGDATA)
        wreg[regsel_r] <= pwdata[7:0];
    end
  end

  // Read data captured in setup so it stands through the access phase
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (ce && setup)
    begin
      case (paddr)
        `CSCB_ADDR_CTRL:
          prdata <= {28'h0000000, state_r, 1'b0, run_r};
        `CSCB_ADDR_PC:
          prdata <= {{(32-PC_W){1'b0}}, pc_r};
        `CSCB_ADDR_FLAGS:
          prdata <= {24'h000000, flags_r};
        `CSCB_ADDR_REGSEL:
          prdata <= {27'h0000000, regsel_r};
        `CSCB_ADDR_REGDATA:
          prdata <= {24'h000000, wreg[regsel_r]};
        `CSCB_ADDR_RETIRED:
          prdata <= retired_r;
        default:
          prdata <= 32'h00000000;
      endcase
    end
  end
endmodule

// ==== src/cscb_defines.vh ====
`ifndef CSCB_DEFINES_VH
`define CSCB_DEFINES_VH

// Register byte addresses on the APB slave
`define CSCB_ADDR_CTRL 8'h00
`define CSCB_ADDR_PC 8'h04
`define CSCB_ADDR_FLAGS 8'h08
`define CSCB_ADDR_REGSEL 8'h0C
`define CSCB_ADDR_REGDATA 8'h10
`define CSCB_ADDR_RETIRED 8'h14

// Control register fields and reset values
`define CSCB_CTRL_RUN 0
`define CSCB_FLAGS_RST 8'h00
`define CSCB_PC_RST 16'h0000

// Status flag positions
`define CSCB_FLAG_C 3'h0
`define CSCB_FLAG_Z 3'h1
`define CSCB_FLAG_N 3'h2
`define CSCB_FLAG_V 3'h3
`define CSCB_FLAG_S 3'h4
`define CSCB_FLAG_H 3'h5

// Instruction classes
`define CSCB_OP_OTHER 4'h0
`define CSCB_OP_COMPARE_SKIP_EQUAL 4'h1
`define CSCB_OP_COMPARE_REGS 4'h2
`define CSCB_OP_COMPARE_REGS_WITH_CARRY 4'h3
`define CSCB_OP_COMPARE_IMMEDIATE 4'h4
`define CSCB_OP_SKIP_REG_BIT_CLEAR 4'h5
`define CSCB_OP_SKIP_REG_BIT_SET 4'h6
`define CSCB_OP_SKIP_IO_BIT_CLEAR 4'h7
`define CSCB_OP_SKIP_IO_BIT_SET 4'h8
`define CSCB_OP_BRANCH_STATUS_BIT_SET 4'h9
`define CSCB_OP_BRANCH_STATUS_BIT_CLEAR 4'hA

// Opcode masks and match patterns
`define CSCB_M6 16'hFC00
`define CSCB_P_COMPARE_SKIP_EQUAL 16'h1000
`define CSCB_P_COMPARE_REGS 16'h1400
`define CSCB_P_COMPARE_REGS_WITH_CARRY 16'h0400
`define CSCB_M4 16'hF000
`define CSCB_P_COMPARE_IMMEDIATE 16'h3000
`define CSCB_M_REG_BIT 16'hFE08
`define CSCB_P_SKIP_REG_BIT_CLEAR 16'hFC00
`define CSCB_P_SKIP_REG_BIT_SET 16'hFE00
`define CSCB_M8 16'hFF00
`define CSCB_P_SKIP_IO_BIT_CLEAR 16'h9900
`define CSCB_P_SKIP_IO_BIT_SET 16'h9B00
`define CSCB_P_BRANCH_STATUS_BIT_SET 16'hF000
`define CSCB_P_BRANCH_STATUS_BIT_CLEAR 16'hF400
// Two-word instructions: direct load/store and long jump/call
`define CSCB_M_LDS 16'hFC0F
`define CSCB_P_LDS 16'h9000
`define CSCB_M_JMP 16'hFE0C
`define CSCB_P_JMP 16'h940C

// Immediate compare destination sits in the upper half of the register file
`define CSCB_IMM_DEST_HI 1'b1

`endif

// ==== src/cscb_cmp.v ====
`include "cscb_defines.vh"

// Subtract without storing; produces the compare flags
module cscb_cmp (
  a,
  b,
  carry_in,
  use_carry,
  zero_in,
  flag_c,
  flag_z,
  flag_n,
  flag_v,
  flag_s,
  flag_h
);
  input wire [7:0] a;
  input wire [7:0] b;
  input wire carry_in;
  input wire use_carry;
  input wire zero_in;
  output wire flag_c;
  output wire flag_z;
  output wire flag_n;
  output wire flag_v;
  output wire flag_s;
  output wire flag_h;

  wire cin;
  wire [7:0] res;

  // Borrow chain flags
  assign cin = use_carry & carry_in;
  assign res = a - b - {7'h00, cin};
  assign flag_h = (~a[3] & b[3]) | (b[3] & res[3]) | (res[3] & ~a[3]);
  assign flag_c = (~a[7] & b[7]) | (b[7] & res[7]) | (res[7] & ~a[7]);
  assign flag_v = (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]);
  assign flag_n = res[7];
  assign flag_s = flag_n ^ flag_v;
  // With carry, zero only stays set so multi-byte compares chain
  assign flag_z = (res == 8'h00) & (~use_carry | zero_in);
endmodule

// ==== test/cscb_pmem.sv ====
module cscb_pmem (
  input logic [15:0] prog_addr,
  output logic [15:0] prog_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] mem [0:7];
  // Spare words branch to self, so a run parks where it lands
  initial
  begin
    for (int i = 0; i < 8; i++)
      mem[i] = 16'hF7FE;
  end
  // Fetch is combinational; words past the array park too
  assign prog_data = (prog_addr < 16'h8) ? mem[prog_addr[2:0]] : 16'hF7FE;
endmodule

// ==== test/cscb_core_chk.sv ====
`include "cscb_defines.vh"
module cscb_core_chk #(
  parameter PC_W = 16
) (
  input logic pclk,
  input logic presetn,
  input logic ce,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic [PC_W-1:0] prog_addr,
  input logic [15:0] prog_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [PC_W-1:0] pa_r;
  logic [15:0] pd_r;
  logic pw_r;
  // Last fetch; no reset needed, the pc reads zero all through reset
  always_ff @(posedge pclk)
  begin
    pa_r <= prog_addr;
    pd_r <= prog_data;
    pw_r <= psel && penable && pwrite && pready && paddr == `CSCB_ADDR_PC;
  end
  // Software pc writes are masked, they move the pc at will
  wire [PC_W-1:0] dl = prog_addr - pa_r;
  wire [PC_W-1:0] kp = {{(PC_W-7){pd_r[9]}}, pd_r[9:3]} + PC_W'(1);
  wire br = (pd_r & 16'hF800) == 16'hF000;
  wire tw = (pd_r & `CSCB_M_LDS) == `CSCB_P_LDS || (pd_r & `CSCB_M_JMP) == `CSCB_P_JMP;
  wire mv = dl != '0 && !pw_r;
  wire acc = psel && penable;
  wire map = paddr[1:0] == 2'h0 && paddr <= 8'h14;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_ready_ce: assert property (pready == ce)
    else $error("ready differs from enable");
  chk_err_unmap: assert property (acc && !map |-> pslverr)
    else $error("no error on unmapped access");
  chk_err_idle: assert property (!acc |-> !pslverr)
    else $error("error outside access");
  chk_err_rdata: assert property (acc && !pwrite && !map |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  chk_step_one: assert property (mv && !br && !tw |-> dl == 1)
    else $error("pc step not one");
  chk_two_word: assert property (mv && tw |-> dl == 1 || dl == 2)
    else $error("bad step over long word");
  chk_skip_wait: assert property (mv && tw && dl == 2 |=> dl == '0 || pw_r)
    else $error("no wait after long skip");
  chk_br_target: assert property (mv && br |-> dl == 1 || dl == kp)
    else $error("bad branch target");
  chk_br_wait: assert property (mv && br && dl == kp && kp > 1 |=> dl == '0 || pw_r)
    else $error("no wait after branch");
  cover property (mv && tw && dl == 2);
  cover property (mv && br && dl == kp && kp > 1);
  cover property (acc && pslverr);
endmodule

// ==== test/tb_top.sv ====
`include "cscb_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [255:0] io_regs_in = 256'h400; // Only I/O bit 1.2 high
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire [15:0] prog_addr;
  wire [15:0] prog_data;
  logic [31:0] rd_v;
  logic [31:0] er_v;
  int num_errors = 0;
  int checks_done = 0;
  always #5 pclk = ~pclk;
  cscb_core uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .prog_addr(prog_addr),
    .prog_data(prog_data), .io_regs_in(io_regs_in));
  cscb_pmem u_mem (.prog_addr(prog_addr), .prog_data(prog_data));
  task stop_test;
    $display("checks %0d, mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h, want %h", $time, got, exp);
    end
  endtask
  // One APB transfer; waits for ready, the watchdog bounds a hang
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd_v = prdata;
    er_v = {31'h0, pslverr};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Run two words at 4 and 5 from given flags, then check pc and flags
  task t_run(input logic [7:0] f, input logic [15:0] w0, input logic [15:0] w1,
    input logic [15:0] pc_e, input logic [7:0] f_e);
    u_mem.mem[4] = w0;
    u_mem.mem[5] = w1;
    apb(1'b1, `CSCB_ADDR_FLAGS, {24'h0, f});
    apb(1'b1, `CSCB_ADDR_PC, 32'h4);
    apb(1'b1, `CSCB_ADDR_CTRL, 32'h1);
    repeat (12) @(posedge pclk);
    apb(1'b1, `CSCB_ADDR_CTRL, 32'h0);
    apb(1'b0, `CSCB_ADDR_PC, 32'h0);
    chk(rd_v, {16'h0, pc_e});
    apb(1'b0, `CSCB_ADDR_FLAGS, 32'h0);
    chk(rd_v, {24'h0, f_e});
  endtask
  // Reset state, unmapped refusal, then r1 = r2 = r16 = 5
  task t_reset;
    apb(1'b0, `CSCB_ADDR_PC, 32'h0);
    chk(rd_v, 32'h0);
    apb(1'b0, 8'h40, 32'h0);
    chk(er_v, 32'h1);
    chk(rd_v, 32'h0);
    apb(1'b1, `CSCB_ADDR_REGSEL, 32'h1);
    apb(1'b1, `CSCB_ADDR_REGDATA, 32'h5);
    apb(1'b1, `CSCB_ADDR_REGSEL, 32'h2);
    apb(1'b1, `CSCB_ADDR_REGDATA, 32'h5);
    apb(1'b1, `CSCB_ADDR_REGSEL, 32'h10);
    apb(1'b1, `CSCB_ADDR_REGDATA, 32'h5);
    apb(1'b0, `CSCB_ADDR_REGDATA, 32'h0);
    chk(rd_v, 32'h5);
    $display("reset test done");
  endtask
  task t_cmp;
    t_run(8'h00, 16'h1412, 16'hF7FE, 16'h5, 8'h02);
    t_run(8'h03, 16'h0412, 16'hF7FE, 16'h5, 8'h35);
    t_run(8'h3C, 16'h0412, 16'hF7FE, 16'h5, 8'h00);
    t_run(8'h02, 16'h3006, 16'hF7FE, 16'h5, 8'h35);
    $display("compare test done");
  endtask
  task t_skip;
    t_run(8'h00, 16'h1012, 16'hF7FE, 16'h6, 8'h00);
    t_run(8'h00, 16'h1012, 16'h940C, 16'h7, 8'h00);
    t_run(8'h00, 16'h1013, 16'hF7FE, 16'h5, 8'h00);
    t_run(8'h00, 16'hFE10, 16'hF7FE, 16'h6, 8'h00);
    t_run(8'h00, 16'hFC10, 16'hF7FE, 16'h5, 8'h00);
    t_run(8'h00, 16'hFC11, 16'h940C, 16'h7, 8'h00);
    t_run(8'h00, 16'h9B0A, 16'hF7FE, 16'h6, 8'h00);
    t_run(8'h00, 16'h990A, 16'hF7FE, 16'h5, 8'h00);
    t_run(8'h00, 16'h990B, 16'h9000, 16'h7, 8'h00);
    $display("skip test done");
  endtask
  task t_branch;
    t_run(8'h01, 16'hF018, 16'hF7FE, 16'h8, 8'h01);
    t_run(8'h00, 16'hF018, 16'hF7FE, 16'h5, 8'h00);
    t_run(8'h00, 16'hF418, 16'hF7FE, 16'h8, 8'h00);
    t_run(8'h01, 16'hF418, 16'hF7FE, 16'h5, 8'h01);
    t_run(8'h04, 16'hF01A, 16'hF7FE, 16'h8, 8'h04);
    t_run(8'h04, 16'hF41A, 16'hF7FE, 16'h5, 8'h04);
    t_run(8'h0C, 16'hF41C, 16'hF7FE, 16'h8, 8'h0C);
    t_run(8'h14, 16'hF41C, 16'hF7FE, 16'h5, 8'h14);
    t_run(8'h14, 16'hF01C, 16'hF7FE, 16'h8, 8'h14);
    t_run(8'h20, 16'hF01D, 16'hF7FE, 16'h8, 8'h20);
    t_run(8'h20, 16'hF41D, 16'hF7FE, 16'h5, 8'h20);
    t_run(8'h02, 16'hF3E9, 16'hF7FE, 16'h2, 8'h02);
    $display("branch test done");
  endtask
  // Enable low must hold the counter and stall the bus; no transfer while low
  task t_freeze;
    u_mem.mem[4] = 16'h0000;
    u_mem.mem[5] = 16'hF7FE;
    apb(1'b1, `CSCB_ADDR_PC, 32'h4);
    apb(1'b1, `CSCB_ADDR_CTRL, 32'h1);
    ce <= 1'b0;
    repeat (4) @(posedge pclk);
    chk({16'h0, prog_addr}, 32'h4);
    chk({31'h0, pready}, 32'h0);
    ce <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({16'h0, prog_addr}, 32'h5);
    apb(1'b1, `CSCB_ADDR_CTRL, 32'h0);
    $display("freeze test done");
  endtask
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_cmp();
    t_skip();
    t_branch();
    t_freeze();
    stop_test();
  end
  // Watchdog; the whole run needs about 810 cycles
  initial
  begin
    #100us;
    num_errors++;
    stop_test();
  end
endmodule
bind cscb_core cscb_core_chk #(.PC_W(PC_W)) u_chk (.pclk(pclk), .presetn(presetn),
  .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .prog_addr(prog_addr),
  .prog_data(prog_data));
